// ==== shared/uregs_cfg.svh ====
// register map constants of the uart register block
// assumes a parallel bus with three address lines and 8-bit data
`ifndef UREGS_CFG_SVH
`define UREGS_CFG_SVH
`define UREGS_A_DATA      3'h0
`define UREGS_A_MASK      3'h1
`define UREGS_A_SRC       3'h2
`define UREGS_A_LCR       3'h3
`define UREGS_A_MCR       3'h4
`define UREGS_A_LSR       3'h5
`define UREGS_A_MSR       3'h6
`define UREGS_A_SPR       3'h7
`define UREGS_A_RESUME_CHAR_ONE      3'h4
`define UREGS_A_RESUME_CHAR_TWO      3'h5
`define UREGS_A_PAUSE_CHAR_ONE     3'h6
`define UREGS_A_PAUSE_CHAR_TWO     3'h7
`define UREGS_LCR_ENH     8'hBF
`define UREGS_LCR_DIV_BIT 7
`define UREGS_EFR_ENH_BIT 4
`define UREGS_FCR_EN_BIT  0
`define UREGS_SRC_NONE    8'h01
`define UREGS_SRC_LINE    4'h6
`define UREGS_SRC_RXRDY   4'h4
`define UREGS_SRC_TXRDY   4'h2
`define UREGS_SRC_MODEM   4'h0
`define UREGS_RST_ZERO    8'h00
`define UREGS_REV_ID      8'h01
`define UREGS_PART_ID     8'h5A
`endif

// ==== shared/uregs_pkg.sv ====
// types shared by the uart register block
// assumes the constants header is compiled alongside
package uregs_pkg;
	typedef logic [7:0] uregs_byte_t;
	typedef enum logic [1:0] {UREGS_BANK_NORM, UREGS_BANK_DIV, UREGS_BANK_ENH} uregs_bank_t;
endpackage : uregs_pkg

// ==== logic/uregs_top.sv ====
// register set of a fifo-buffered uart with receive trigger interrupt
// assumes rx fifo fill and line events come from receiver logic on ref_clk;
// the parallel bus strobes are pins and are synchronised here
//
// How it works
// - upper mask, upper fcr and mcr bits and fraction register act only when enhanced bit 4 set
// - mask gates rx data, tx empty, line and modem sources; shown in source reg
// - trigger interrupt behaviour needs fifo enable and rx data mask bit both one
// - rx data interrupt asserts at trigger fill, drops below trigger fill
// - source bits 3:0 show code 4 (bit 2) for trigger condition unless line code 6 is pending, and clear with it
// - data ready flag sets on char into fifo, clears only when fifo empty
// - address 000 in the normal bank is read for received data and write for outgoing data
// - source bit 0 is one when nothing pending, zero otherwise
`include "uregs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module uregs_top #(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [2:0]        bus_addr,
	input  wire logic              bus_rd_n,
	input  wire logic              bus_wr_n,
	input  wire logic [7:0]        bus_wdata,
	output var  logic [7:0]        bus_rdata,
	output var  logic              bus_rdata_oe,
	output var  logic              irq_out,
	input  wire logic [7:0]        rx_char,
	input  wire logic              rx_char_valid,
	output var  logic              rx_char_ready,
	input  wire logic              tx_empty,
	input  wire logic              line_err,
	input  wire logic              modem_chg,
	input  wire logic [5:0]        rx_fill,
	output var  logic [7:0]        tx_char,
	output var  logic              tx_char_valid,
	input  wire logic              tx_char_ready,
	output var  logic              rx_pop,
	output var  uregs_pkg::uregs_byte_t fraction_out
);
	import uregs_pkg::*;

	initial begin
		if (FIFO_DEPTH < 2 || FIFO_DEPTH > 63) $error("FIFO_DEPTH out of range");
	end

	// strobe synchronisers, two flops each before any logic
	logic [1:0] rd_s_reg, wr_s_reg;
	logic       rd_prev_reg, wr_prev_reg;
	logic [2:0] addr_s1_reg, addr_s2_reg;
	logic [7:0] wd_s1_reg, wd_s2_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_s_reg    <= 2'h0;
			wr_s_reg    <= 2'h0;
			rd_prev_reg <= 1'b0;
			wr_prev_reg <= 1'b0;
			addr_s1_reg <= 3'h0;
			addr_s2_reg <= 3'h0;
			wd_s1_reg   <= 8'h00;
			wd_s2_reg   <= 8'h00;
		end else begin
			rd_s_reg    <= {rd_s_reg[0], ~bus_rd_n};
			wr_s_reg    <= {wr_s_reg[0], ~bus_wr_n};
			rd_prev_reg <= rd_s_reg[1];
			wr_prev_reg <= wr_s_reg[1];
			addr_s1_reg <= bus_addr;
			addr_s2_reg <= addr_s1_reg;
			wd_s1_reg   <= bus_wdata;
			wd_s2_reg   <= wd_s1_reg;
		end
	end
	logic rd_go, wr_go, rd_act;
	assign rd_go  = rd_s_reg[1] & ~rd_prev_reg;
	assign wr_go  = wr_s_reg[1] & ~wr_prev_reg;
	assign rd_act = rd_s_reg[1];

	// registers
	uregs_byte_t lcr_reg, mask_reg, fcr_reg, mcr_reg, spr_reg, dll_reg, dlm_reg;
	uregs_byte_t frac_reg, efr_reg, feature_control_reg, resume_char_one_reg, resume_char_two_reg, pause_char_one_reg, pause_char_two_reg;
	logic        enh_on;
	assign enh_on = efr_reg[`UREGS_EFR_ENH_BIT];

	// bank selection from the line control value
	function automatic uregs_bank_t bank_of(input uregs_byte_t line_control_reg);
		if (line_control_reg == `UREGS_LCR_ENH) bank_of = UREGS_BANK_ENH;
		else if (line_control_reg[`UREGS_LCR_DIV_BIT]) bank_of = UREGS_BANK_DIV;
		else bank_of = UREGS_BANK_NORM;
	endfunction : bank_of
	uregs_bank_t bank;
	assign bank = bank_of(lcr_reg);

	// two-entry transmit buffer between host writes and the transmitter
	logic [7:0] txb_q [2];
	logic [1:0] txb_cnt_reg;
	logic       txb_wr_ptr_reg, txb_rd_ptr_reg;
	logic       tx_push, tx_pull;
	assign tx_push = wr_go && bank == UREGS_BANK_NORM && addr_s2_reg == `UREGS_A_DATA
		&& txb_cnt_reg != 2'h2;
	assign tx_pull = tx_char_valid && tx_char_ready;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			txb_q[0]       <= 8'h00;
			txb_q[1]       <= 8'h00;
			txb_cnt_reg    <= 2'h0;
			txb_wr_ptr_reg <= 1'b0;
			txb_rd_ptr_reg <= 1'b0;
		end else begin
			if (tx_push) begin
				txb_q[txb_wr_ptr_reg] <= wd_s2_reg;
				txb_wr_ptr_reg        <= ~txb_wr_ptr_reg;
			end
			if (tx_pull) txb_rd_ptr_reg <= ~txb_rd_ptr_reg;
			txb_cnt_reg <= txb_cnt_reg + {1'b0, tx_push} - {1'b0, tx_pull};
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_char       <= 8'h00;
			tx_char_valid <= 1'b0;
		end else begin
			// a byte pushed into an empty slot is forwarded, as its store lands only now
			if (tx_push && txb_wr_ptr_reg == (txb_rd_ptr_reg ^ tx_pull))
				tx_char <= wd_s2_reg;
			else
				tx_char <= txb_q[txb_rd_ptr_reg ^ tx_pull];
			tx_char_valid <= (txb_cnt_reg + {1'b0, tx_push} - {1'b0, tx_pull}) != 2'h0;
		end
	end

	// register writes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lcr_reg  <= `UREGS_RST_ZERO; mask_reg <= `UREGS_RST_ZERO;
			fcr_reg  <= `UREGS_RST_ZERO; mcr_reg  <= `UREGS_RST_ZERO;
			spr_reg  <= `UREGS_RST_ZERO; dll_reg  <= `UREGS_RST_ZERO;
			dlm_reg  <= `UREGS_RST_ZERO; frac_reg <= `UREGS_RST_ZERO;
			efr_reg  <= `UREGS_RST_ZERO; feature_control_reg <= `UREGS_RST_ZERO;
			resume_char_one_reg <= `UREGS_RST_ZERO; resume_char_two_reg <= `UREGS_RST_ZERO;
			pause_char_one_reg <= `UREGS_RST_ZERO; pause_char_two_reg <= `UREGS_RST_ZERO;
		end else if (wr_go) begin
			if (addr_s2_reg == `UREGS_A_LCR) lcr_reg <= wd_s2_reg;
			else if (bank == UREGS_BANK_ENH) begin
				if (addr_s2_reg == 3'h1) feature_control_reg <= wd_s2_reg;
				else if (addr_s2_reg == 3'h2) efr_reg <= wd_s2_reg;
				else if (addr_s2_reg == `UREGS_A_RESUME_CHAR_ONE) resume_char_one_reg <= wd_s2_reg;
				else if (addr_s2_reg == `UREGS_A_RESUME_CHAR_TWO) resume_char_two_reg <= wd_s2_reg;
				else if (addr_s2_reg == `UREGS_A_PAUSE_CHAR_ONE) pause_char_one_reg <= wd_s2_reg;
				else if (addr_s2_reg == `UREGS_A_PAUSE_CHAR_TWO) pause_char_two_reg <= wd_s2_reg;
			end else if (bank == UREGS_BANK_DIV && addr_s2_reg == 3'h0) dll_reg <= wd_s2_reg;
			else if (bank == UREGS_BANK_DIV && addr_s2_reg == 3'h1) dlm_reg <= wd_s2_reg;
			else if (bank == UREGS_BANK_DIV && addr_s2_reg == 3'h2) begin
				if (enh_on) frac_reg <= wd_s2_reg;
			end else if (addr_s2_reg == `UREGS_A_MASK) begin
				// upper mask bits only writable in enhanced mode
				mask_reg <= enh_on ? wd_s2_reg : {4'h0, wd_s2_reg[3:0]};
			end else if (addr_s2_reg == `UREGS_A_SRC) begin
				fcr_reg <= enh_on ? wd_s2_reg : {wd_s2_reg[7:6], 3'h0, wd_s2_reg[2:0]};
			end else if (addr_s2_reg == `UREGS_A_MCR) begin
				mcr_reg <= enh_on ? wd_s2_reg : {3'h0, wd_s2_reg[4:0]};
			end else if (addr_s2_reg == `UREGS_A_SPR) spr_reg <= wd_s2_reg;
		end
	end

	// fraction register drives the baud logic only in enhanced mode
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) fraction_out <= 8'h00;
		else fraction_out <= enh_on ? frac_reg : 8'h00;
	end

	// two-entry receive buffer before the holding location
	logic [7:0] rxb_q [2];
	logic [1:0] rxb_cnt_reg;
	logic       rxb_wr_ptr_reg, rxb_rd_ptr_reg, rx_in, rx_out;
	assign rx_in  = rx_char_valid && rx_char_ready;
	assign rx_out = rd_go && bank == UREGS_BANK_NORM && addr_s2_reg == `UREGS_A_DATA
		&& rxb_cnt_reg != 2'h0;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rxb_q[0]       <= 8'h00;
			rxb_q[1]       <= 8'h00;
			rxb_cnt_reg    <= 2'h0;
			rxb_wr_ptr_reg <= 1'b0;
			rxb_rd_ptr_reg <= 1'b0;
			rx_char_ready  <= 1'b0;
			rx_pop         <= 1'b0;
		end else begin
			if (rx_in) begin
				rxb_q[rxb_wr_ptr_reg] <= rx_char;
				rxb_wr_ptr_reg        <= ~rxb_wr_ptr_reg;
			end
			if (rx_out) rxb_rd_ptr_reg <= ~rxb_rd_ptr_reg;
			rxb_cnt_reg   <= rxb_cnt_reg + {1'b0, rx_in} - {1'b0, rx_out};
			rx_char_ready <= (rxb_cnt_reg + {1'b0, rx_in} - {1'b0, rx_out}) != 2'h2;
			rx_pop        <= rx_out;
		end
	end

	// data ready: set on arrival, cleared only when empty
	logic data_ready;
	assign data_ready = rxb_cnt_reg != 2'h0 || rx_fill != 6'h00;

	// receive trigger level from fifo control bits 7:6
	logic [5:0] trig_lvl;
	always_comb begin
		case (fcr_reg[7:6])
			2'h0: trig_lvl = 6'h01;
			2'h1: trig_lvl = 6'h08;
			2'h2: trig_lvl = 6'h10;
			default: trig_lvl = 6'h1C;
		endcase
	end
	logic fifo_on, rx_trig, rx_int, tx_int, line_int, modem_int;
	assign fifo_on  = fcr_reg[`UREGS_FCR_EN_BIT];
	assign rx_trig  = fifo_on ? (rx_fill + {4'h0, rxb_cnt_reg}) >= trig_lvl : data_ready;
	assign rx_int   = mask_reg[0] && rx_trig;
	assign tx_int   = mask_reg[1] && tx_empty;
	assign line_int = mask_reg[2] && line_err;
	assign modem_int = mask_reg[3] && modem_chg;

	// interrupt source and output, by priority
	uregs_byte_t src_val;
	always_comb begin
		src_val = `UREGS_SRC_NONE;
		if (line_int) src_val = {4'h0, `UREGS_SRC_LINE};
		else if (rx_int) src_val = {4'h0, `UREGS_SRC_RXRDY};
		else if (tx_int) src_val = {4'h0, `UREGS_SRC_TXRDY};
		else if (modem_int) src_val = {4'h0, `UREGS_SRC_MODEM};
		if (fifo_on) src_val[7:6] = 2'h3;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) irq_out <= 1'b0;
		else irq_out <= line_int | rx_int | tx_int | modem_int;
	end

	// read mux
	uregs_byte_t rd_val;
	always_comb begin
		rd_val = 8'h00;
		if (addr_s2_reg == `UREGS_A_LCR) rd_val = lcr_reg;
		else if (bank == UREGS_BANK_ENH) begin
			if (addr_s2_reg == 3'h0) rd_val = rx_fill[5:0] + 8'h00;
			else if (addr_s2_reg == 3'h1) rd_val = feature_control_reg;
			else if (addr_s2_reg == 3'h2) rd_val = efr_reg;
			else if (addr_s2_reg == `UREGS_A_RESUME_CHAR_ONE) rd_val = resume_char_one_reg;
			else if (addr_s2_reg == `UREGS_A_RESUME_CHAR_TWO) rd_val = resume_char_two_reg;
			else if (addr_s2_reg == `UREGS_A_PAUSE_CHAR_ONE) rd_val = pause_char_one_reg;
			else if (addr_s2_reg == `UREGS_A_PAUSE_CHAR_TWO) rd_val = pause_char_two_reg;
		end else if (bank == UREGS_BANK_DIV && addr_s2_reg == 3'h0) begin
			rd_val = (dll_reg == 8'h00 && dlm_reg == 8'h00) ? `UREGS_REV_ID : dll_reg;
		end else if (bank == UREGS_BANK_DIV && addr_s2_reg == 3'h1) begin
			rd_val = (dll_reg == 8'h00 && dlm_reg == 8'h00) ? `UREGS_PART_ID : dlm_reg;
		end else if (bank == UREGS_BANK_DIV && addr_s2_reg == 3'h2) rd_val = frac_reg;
		else if (addr_s2_reg == `UREGS_A_DATA) rd_val = rxb_q[rxb_rd_ptr_reg];
		else if (addr_s2_reg == `UREGS_A_MASK) rd_val = mask_reg;
		else if (addr_s2_reg == `UREGS_A_SRC) rd_val = src_val;
		else if (addr_s2_reg == `UREGS_A_MCR) rd_val = mcr_reg;
		else if (addr_s2_reg == `UREGS_A_LSR) rd_val = {1'b0, tx_empty, tx_empty, 4'h0, data_ready};
		else if (addr_s2_reg == `UREGS_A_SPR) rd_val = spr_reg;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_rdata    <= 8'h00;
			bus_rdata_oe <= 1'b0;
		end else begin
			if (rd_go) bus_rdata <= rd_val;
			bus_rdata_oe <= rd_act;
		end
	end

	// source bit 0 low exactly when the output is asserted on the next cycle
	a_src_idle_bit: assert property (@(posedge ref_clk) disable iff (rst)
		src_val[0] == !(line_int | rx_int | tx_int | modem_int) |=> irq_out == !$past(src_val[0]))
		else $error("source idle bit disagrees with interrupt");
	a_pop_on_read: assert property (@(posedge ref_clk) disable iff (rst)
		rx_out |=> rx_pop)
		else $error("holding read without pop pulse");
	a_oe_follows_rd: assert property (@(posedge ref_clk) disable iff (rst)
		rd_act |=> bus_rdata_oe)
		else $error("read data not enabled during read");
	a_mask_gates_rx: assert property (@(posedge ref_clk) disable iff (rst)
		!mask_reg[0] |-> !rx_int)
		else $error("rx interrupt while masked");
	a_trig_level: assert property (@(posedge ref_clk) disable iff (rst)
		(fifo_on && mask_reg[0] && rx_fill + {4'h0, rxb_cnt_reg} < trig_lvl) |-> !rx_int)
		else $error("rx interrupt below trigger level");
	a_src_rx_code: assert property (@(posedge ref_clk) disable iff (rst)
		(rx_int && !line_int) |-> src_val[3:0] == 4'h4)
		else $error("trigger code not in source bits");
	a_ready_flag: assert property (@(posedge ref_clk) disable iff (rst)
		rx_in |=> data_ready)
		else $error("data ready not set after arrival");
	a_enh_frac: assert property (@(posedge ref_clk) disable iff (rst)
		!enh_on |=> fraction_out == 8'h00)
		else $error("fraction active without enhanced mode");
	a_mask_upper: assert property (@(posedge ref_clk) disable iff (rst)
		(wr_go && !enh_on && bank == UREGS_BANK_NORM && addr_s2_reg == `UREGS_A_MASK)
		|=> mask_reg[7:4] == 4'h0)
		else $error("upper mask bits written without enhanced mode");
	a_tx_only_write: assert property (@(posedge ref_clk) disable iff (rst)
		tx_push |-> wr_go && addr_s2_reg == 3'h0)
		else $error("transmit push without data write");
	a_bank_enh: assert property (@(posedge ref_clk) disable iff (rst)
		lcr_reg == 8'hBF |-> bank == UREGS_BANK_ENH)
		else $error("enhanced bank not selected");
	a_line_gate: assert property (@(posedge ref_clk) disable iff (rst)
		(line_err && mask_reg[2]) |=> irq_out)
		else $error("line interrupt not raised");
endmodule : uregs_top
`default_nettype wire

// ==== verification/uregs_host.sv ====
// host processor model: drives the parallel register bus pins
// assumes the block synchronises strobes, so each phase lasts several cycles
`timescale 1ns/10ps
`default_nettype none
module uregs_host (
	input  wire logic       ref_clk,
	output var  logic [2:0] bus_addr,
	output var  logic       bus_rd_n,
	output var  logic       bus_wr_n,
	output var  logic [7:0] bus_wdata,
	input  wire logic [7:0] bus_rdata,
	output var  logic       rd_done,
	output var  logic [7:0] rd_data
);
	// idle bus with both strobes released
	initial begin
		bus_addr = 3'h0;
		bus_rd_n = 1'b1;
		bus_wr_n = 1'b1;
		bus_wdata = 8'h00;
		rd_done = 1'b0;
		rd_data = 8'h00;
	end
	// step n edges, then move off the edge
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_clk
	// write: address and data settle three cycles before the strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus_addr = a;
		bus_wdata = d;
		wait_clk(3);
		bus_wr_n = 1'b0;
		wait_clk(5);
		bus_wr_n = 1'b1;
		wait_clk(5);
		bus_wdata = ~d; // released data no longer shows the byte
	endtask : wr
	// read: byte taken six edges into the strobe, then reported for one cycle
	task automatic rd(input logic [2:0] a);
		bus_addr = a;
		wait_clk(3);
		bus_rd_n = 1'b0;
		wait_clk(6);
		rd_data = bus_rdata;
		rd_done = 1'b1;
		bus_rd_n = 1'b1;
		wait_clk(1);
		rd_done = 1'b0;
		wait_clk(4);
	endtask : rd
endmodule : uregs_host
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench of the uart register block with a host bus model
// assumes receiver and transmitter sides are played by this bench
`include "uregs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
	import uregs_pkg::*;
	logic        ref_clk, rst, bus_rd_n, bus_wr_n, bus_rdata_oe, irq_out, rd_done;
	logic        rx_char_valid, rx_char_ready, tx_empty, line_err, modem_chg;
	logic        tx_char_valid, tx_char_ready, rx_pop;
	logic [2:0]  bus_addr;
	logic [5:0]  rx_fill;
	logic [7:0]  bus_wdata, bus_rdata, rx_char, tx_char, rd_data, v;
	uregs_byte_t fraction_out;
	logic [7:0]  ch [3];
	logic [15:0] e;
	logic [15:0] rd_q [$];
	logic [7:0]  tx_q [$];
	int          fails, num_checks;
	int          lvl [4] = '{1, 8, 16, 28};
	logic [3:0]  codes [4] = '{`UREGS_SRC_RXRDY, `UREGS_SRC_TXRDY, `UREGS_SRC_LINE, `UREGS_SRC_MODEM};
	uregs_top #(.FIFO_DEPTH(32)) i_uregs_top (.*);
	uregs_host i_uregs_host (.*);
	always #5 ref_clk = ~ref_clk;
	// print counts and verdict, then stop
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	// note the expected byte under mask, then read
	task automatic chk_rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
		rd_q.push_back({m, x});
		i_uregs_host.rd(a);
	endtask : chk_rd
	// bit 0 rx fill, bit 1 tx empty, bit 2 line error, bit 3 modem change
	task automatic set_ev(input logic [3:0] ev);
		rx_fill = {5'h00, ev[0]};
		tx_empty = ev[1];
		line_err = ev[2];
		modem_chg = ev[3];
	endtask : set_ev
	// hand one char to the receive buffer, held until taken
	task automatic push(input logic [7:0] c);
		rx_char = c;
		rx_char_valid = 1'b1;
		// ready is looked at one unit after the edge, where it has settled
		while (rx_char_ready !== 1'b1) begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
		#1;
		rx_char_valid = 1'b0;
	endtask : push
	// compare each reported read and each transmit handoff with its oldest note
	always @(posedge ref_clk) begin
		if (rd_done === 1'b1) begin
			e = rd_q.pop_front();
			`CHK(rd_data & e[15:8], e[7:0])
		end
		if (tx_char_valid === 1'b1 && tx_char_ready === 1'b1) begin
			`CHK(tx_char, tx_q.pop_front())
		end
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (30000) @(posedge ref_clk);
		fails++;
		close_out();
	end
	// main sequence
	initial begin
		void'($urandom(32'h97DF));
		ref_clk = 1'b0;
		rst = 1'b1;
		rx_char = 8'h00;
		rx_char_valid = 1'b0;
		tx_char_ready = 1'b0;
		set_ev(4'h0);
		repeat (16) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		i_uregs_host.wait_clk(2);
		chk_rd(`UREGS_A_SRC, `UREGS_SRC_NONE);
		// divisor bank: zero divisor shows identity bytes, then latches read back
		i_uregs_host.wr(`UREGS_A_LCR, 8'h80);
		chk_rd(3'h0, `UREGS_REV_ID);
		chk_rd(3'h1, `UREGS_PART_ID);
		i_uregs_host.wr(3'h0, 8'h34);
		i_uregs_host.wr(3'h1, 8'h12);
		chk_rd(3'h0, 8'h34);
		chk_rd(3'h1, 8'h12);
		i_uregs_host.wr(3'h2, 8'hA5);
		`CHK(fraction_out, 8'h00)
		// enhanced bank: feature bit and flow-control characters
		i_uregs_host.wr(`UREGS_A_LCR, `UREGS_LCR_ENH);
		i_uregs_host.wr(3'h2, 8'h10);
		for (int i = 4; i < 8; i++) begin
			v = 8'($urandom);
			i_uregs_host.wr(3'(i), v);
			chk_rd(3'(i), v);
		end
		chk_rd(3'h2, 8'h10);
		i_uregs_host.wr(`UREGS_A_LCR, 8'h80);
		i_uregs_host.wr(3'h2, 8'hA5);
		`CHK(fraction_out, 8'hA5)
		i_uregs_host.wr(`UREGS_A_LCR, 8'h03);
		i_uregs_host.wr(`UREGS_A_SRC, 8'h01);
		// each source is gated by its own mask bit only
		for (int i = 0; i < 4; i++) begin
			i_uregs_host.wr(`UREGS_A_MASK, 8'(1 << i));
			set_ev(~(4'h1 << i));
			chk_rd(`UREGS_A_SRC, 8'hC1);
			`CHK(irq_out, 1'b0)
			set_ev(4'h1 << i);
			chk_rd(`UREGS_A_SRC, {4'hC, codes[i]});
			`CHK(irq_out, 1'b1)
		end
		// every trigger level: one below stays quiet, at the level it fires
		i_uregs_host.wr(`UREGS_A_MASK, 8'h01);
		set_ev(4'h0);
		for (int t = 0; t < 4; t++) begin
			i_uregs_host.wr(`UREGS_A_SRC, {2'(t), 6'h01});
			rx_fill = 6'(lvl[t] - 1);
			chk_rd(`UREGS_A_SRC, 8'hC1);
			`CHK(irq_out, 1'b0)
			rx_fill = 6'(lvl[t]);
			chk_rd(`UREGS_A_SRC, 8'hC4);
			`CHK(irq_out, 1'b1)
		end
		// fifo off: no trigger level, data present alone raises the rx interrupt
		i_uregs_host.wr(`UREGS_A_SRC, 8'h00);
		chk_rd(`UREGS_A_SRC, 8'h04);
		`CHK(irq_out, 1'b1)
		i_uregs_host.wr(`UREGS_A_MASK, 8'h00);
		chk_rd(`UREGS_A_SRC, `UREGS_SRC_NONE);
		`CHK(irq_out, 1'b0)
		// receive buffer: fill until refused, drain through the holding location
		set_ev(4'h0);
		for (int i = 0; i < 2; i++) begin
			ch[i] = 8'($urandom);
			push(ch[i]);
		end
		i_uregs_host.wait_clk(2);
		`CHK(rx_char_ready, 1'b0)
		chk_rd(`UREGS_A_LSR, 8'h01, 8'h01);
		chk_rd(`UREGS_A_DATA, ch[0]);
		chk_rd(`UREGS_A_LSR, 8'h01, 8'h01);
		chk_rd(`UREGS_A_DATA, ch[1]);
		chk_rd(`UREGS_A_LSR, 8'h00, 8'h01);
		// transmit buffer: third write while stalled is dropped
		for (int i = 0; i < 3; i++) begin
			ch[i] = 8'($urandom);
			i_uregs_host.wr(`UREGS_A_DATA, ch[i]);
		end
		tx_q.push_back(ch[0]);
		tx_q.push_back(ch[1]);
		tx_char_ready = 1'b1;
		i_uregs_host.wait_clk(8);
		`CHK(1'(tx_q.size() == 0), 1'b1)
		close_out();
	end
endmodule : testbench
`default_nettype wire
